/* File: pkg/cmc_params.svh */
// constants for the counter measurement control block
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH
`define CMC_CLK_MHZ          125
`define CMC_REF_1MHZ_NS      1000
`define CMC_RST_PULSE_CYC    4
`define CMC_XFER_PULSE_CYC   2
`define CMC_DISP_CNT_W       32
`define CMC_DISP_CNT_RESET   32'h07735940
`define CMC_ADDR_CTRL        4'h0
`define CMC_ADDR_DISP_TIME   4'h1
`define CMC_ADDR_STATUS      4'h2
`define CMC_CTRL_MODE_LSB    0
`define CMC_CTRL_SINGLE_BIT  3
`endif

/* File: pkg/cmc_pkg.sv */
// types for the counter measurement control block
package cmc_pkg;
   typedef enum logic [2:0] {
      CMC_FREQ  = 3'h0,
      CMC_PER   = 3'h1,
      CMC_TINT  = 3'h2,
      CMC_RATIO = 3'h3,
      CMC_TOTAL = 3'h4
   } cmc_mode_type;

   // one register bus request
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } cmc_bus_req_type;

   // outward pulses and levels towards display chain and printer
   typedef struct packed {
      logic reset_pulse;
      logic transfer;
      logic print_cmd;
   } cmc_disp_out_type;

   typedef enum {
      CMC_ST_IDLE,
      CMC_ST_COUNT,
      CMC_ST_DISPLAY
   } cmc_phase_type;
endpackage : cmc_pkg

/* File: src/cmc_control.sv */
// measurement gate, display timer, reset and transfer control
// How it works
// - gate offered channel A in freq/ratio, 1 MHz in period, time base otherwise
// - time base path enabled when neither channel A nor reference path selected
// - trigger edge opens main gate; next edge closes it, display period starts
// - closing edge sets display flop; it drives print command and releases timer clamp
// - end-of-display reset clears display flop; cleared flop keeps timer inhibited
// - released timer runs display time then fires one fixed-width reset pulse
// - single-shot setting: timer never fires; manual reset gives one update
// - reset pulse goes active high to time base and display chain
// - flops cleared by active-low reset; stop kept apart from electronic reset
// - short transfer pulse derived from main gate closing edge
// - time interval and totalize hold transfer continuously active
// - manual reset gives reset pulse plus transfer pulse
// - start button opens main gate; stop button closes it
// - hold high blocks trigger edges and clamps display timer; start button still opens main gate
// - falling edge of hold gives an immediate reset pulse
// - all triggers blocked from display start until general reset
// - freq/period/ratio trigger from time base; others from start/stop events
//
// Chosen here: strobed register access and the register offsets.
`include "cmc_params.svh"
module cmc_control
   import cmc_pkg::*;
(
   // clock, reset, enable
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // measured signals, already on this clock
   input  wire logic        chan_a,
   input  wire logic        ref_1mhz,
   input  wire logic        time_base_out,
   input  wire logic        start_event,
   input  wire logic        stop_event,
   // panel and printer pins
   input  wire logic        manual_reset_button,
   input  wire logic        start_button,
   input  wire logic        stop_button,
   input  wire logic        printer_hold,
   // outputs
   output logic             count_gate,
   output logic             print_cmd,
   output logic             reset_pulse,
   output logic             transfer
);
   localparam int RST_W = `CMC_RST_PULSE_CYC;
   localparam int XFR_W = `CMC_XFER_PULSE_CYC;

   // software state
   logic [2:0]  mode_reg;
   logic        single_shot_switch_reg;
   logic [31:0] display_time_control_reg;
   // control flops
   logic        main_gate_flop_reg;
   logic        display_flop_reg;
   logic [31:0] disp_cnt_reg;
   logic [2:0]  rst_cnt_reg;
   logic [1:0]  xfr_cnt_reg;
   logic        tb_d_reg;
   logic        st_d_reg;
   logic        sp_d_reg;

   // three-stage synchronisers for pins
   logic [2:0] mr_s_reg;
   logic [2:0] sb_s_reg;
   logic [2:0] pb_s_reg;
   logic [2:0] hd_s_reg;
   logic       mr_lv_reg;
   logic       sb_lv_reg;
   logic       pb_lv_reg;
   logic       hd_lv_reg;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mr_s_reg <= 3'h0;
         sb_s_reg <= 3'h0;
         pb_s_reg <= 3'h0;
         hd_s_reg <= 3'h0;
      end else if (clk_en) begin
         mr_s_reg <= {mr_s_reg[1:0], manual_reset_button};
         sb_s_reg <= {sb_s_reg[1:0], start_button};
         pb_s_reg <= {pb_s_reg[1:0], stop_button};
         hd_s_reg <= {hd_s_reg[1:0], printer_hold};
      end
   end

   // a level counts only once stages two and three agree
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mr_lv_reg <= 1'b0;
         sb_lv_reg <= 1'b0;
         pb_lv_reg <= 1'b0;
         hd_lv_reg <= 1'b0;
      end else if (clk_en) begin
         if (mr_s_reg[1] == mr_s_reg[2]) mr_lv_reg <= mr_s_reg[2];
         if (sb_s_reg[1] == sb_s_reg[2]) sb_lv_reg <= sb_s_reg[2];
         if (pb_s_reg[1] == pb_s_reg[2]) pb_lv_reg <= pb_s_reg[2];
         if (hd_s_reg[1] == hd_s_reg[2]) hd_lv_reg <= hd_s_reg[2];
      end
   end

   wire mr_next = (mr_s_reg[1] == mr_s_reg[2]) ? mr_s_reg[2] : mr_lv_reg;
   wire sb_next = (sb_s_reg[1] == sb_s_reg[2]) ? sb_s_reg[2] : sb_lv_reg;
   wire pb_next = (pb_s_reg[1] == pb_s_reg[2]) ? pb_s_reg[2] : pb_lv_reg;
   wire hd_next = (hd_s_reg[1] == hd_s_reg[2]) ? hd_s_reg[2] : hd_lv_reg;
   wire manual_rise = mr_next & ~mr_lv_reg;
   wire start_rise  = sb_next & ~sb_lv_reg;
   wire stop_rise   = pb_next & ~pb_lv_reg;
   wire hold_level  = hd_lv_reg;
   wire hold_fall   = ~hd_next & hd_lv_reg;

   // mode decode and signal selection
   cmc_mode_type mode;
   assign mode = cmc_mode_type'(mode_reg);
   wire sel_chan_a = (mode == CMC_FREQ) || (mode == CMC_RATIO);
   wire sel_ref    = (mode == CMC_PER);
   wire sel_tb     = ~sel_chan_a & ~sel_ref;
   wire gate_src   = (sel_chan_a & chan_a) | (sel_ref & ref_1mhz) | (sel_tb & time_base_out);
   wire event_mode = (mode == CMC_TINT) || (mode == CMC_TOTAL);

   // trigger edges into the main gate flop
   wire tb_edge = time_base_out & ~tb_d_reg;
   wire st_edge = start_event & ~st_d_reg;
   wire sp_edge = stop_event & ~sp_d_reg;
   wire trig_ok = ~display_flop_reg & ~hold_level;
   wire trig_open  = trig_ok & (event_mode ? st_edge & ~main_gate_flop_reg : tb_edge & ~main_gate_flop_reg);
   wire trig_close = trig_ok & (event_mode ? sp_edge & main_gate_flop_reg : tb_edge & main_gate_flop_reg);
   wire gate_close = main_gate_flop_reg & (trig_close | stop_rise);

   // display timer and reset pulse sources
   wire timer_run  = display_flop_reg & ~hold_level;
   wire timer_fire = timer_run & ~single_shot_switch_reg & (rst_cnt_reg == 3'h0)
                     & (disp_cnt_reg >= display_time_control_reg);
   wire rst_start  = timer_fire | manual_rise | hold_fall;
   wire gen_rst_b  = ~(rst_cnt_reg != 3'h0);                        // active-low for the flops

   // register decode
   wire hit_ctrl = reg_addr == `CMC_ADDR_CTRL;
   wire hit_time = reg_addr == `CMC_ADDR_DISP_TIME;
   wire hit_stat = reg_addr == `CMC_ADDR_STATUS;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mode_reg                 <= 3'h0;
         single_shot_switch_reg   <= 1'b0;
         display_time_control_reg <= `CMC_DISP_CNT_RESET;
         reg_rdata                <= 32'h0;
      end else if (clk_en) begin
         if (reg_wr && hit_ctrl) begin
            mode_reg               <= reg_wdata[`CMC_CTRL_MODE_LSB +: 3];
            single_shot_switch_reg <= reg_wdata[`CMC_CTRL_SINGLE_BIT];
         end
         if (reg_wr && hit_time) display_time_control_reg <= reg_wdata;
         if (reg_rd && hit_ctrl)
            reg_rdata <= {28'h0, single_shot_switch_reg, mode_reg};
         else if (reg_rd && hit_time)
            reg_rdata <= display_time_control_reg;
         else if (reg_rd && hit_stat)
            reg_rdata <= {28'h0, hold_level, reset_pulse, display_flop_reg, main_gate_flop_reg};
         else
            reg_rdata <= 32'h0;
      end
   end

   // main gate and display flops, cleared by the active-low general reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         main_gate_flop_reg <= 1'b0;
         display_flop_reg   <= 1'b0;
      end else if (clk_en) begin
         if (!gen_rst_b) begin
            main_gate_flop_reg <= 1'b0;
            display_flop_reg   <= 1'b0;
         end else begin
            if (gate_close)
               main_gate_flop_reg <= 1'b0;
            else if (trig_open || (start_rise && !display_flop_reg))
               main_gate_flop_reg <= 1'b1;
            if (main_gate_flop_reg && trig_close)
               display_flop_reg <= 1'b1;
         end
      end
   end

   // display timer count; clamped at zero while inhibited
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         disp_cnt_reg <= 32'h0;
      end else if (clk_en) begin
         if (!timer_run || !gen_rst_b)
            disp_cnt_reg <= 32'h0;
         else if (disp_cnt_reg < display_time_control_reg)
            disp_cnt_reg <= disp_cnt_reg + 32'h1;
      end
   end

   // reset pulse width and transfer pulse width counters, edge delays
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rst_cnt_reg    <= 3'h0;
         xfr_cnt_reg    <= 2'h0;
         tb_d_reg       <= 1'b0;
         st_d_reg       <= 1'b0;
         sp_d_reg       <= 1'b0;
      end else if (clk_en) begin
         if (rst_start && rst_cnt_reg == 3'h0)
            rst_cnt_reg <= 3'(RST_W);
         else if (rst_cnt_reg != 3'h0)
            rst_cnt_reg <= rst_cnt_reg - 3'h1;
         if (gate_close || manual_rise)
            xfr_cnt_reg <= 2'(XFR_W);
         else if (xfr_cnt_reg != 2'h0)
            xfr_cnt_reg <= xfr_cnt_reg - 2'h1;
         tb_d_reg       <= time_base_out;
         st_d_reg       <= start_event;
         sp_d_reg       <= stop_event;
      end
   end

   // outputs straight from flops
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         count_gate  <= 1'b0;
         print_cmd   <= 1'b0;
         reset_pulse <= 1'b0;
         transfer    <= 1'b0;
      end else if (clk_en) begin
         count_gate  <= main_gate_flop_reg & gate_src;
         print_cmd   <= display_flop_reg;
         reset_pulse <= ~gen_rst_b;
         transfer    <= event_mode | (xfr_cnt_reg != 2'h0);
      end
   end

   // the gate must never be open during the display period
   property p_gate_closed_in_display;
      @(posedge clock) disable iff (!rst_b)
      display_flop_reg |-> !main_gate_flop_reg;
   endproperty
   a_gate_closed_in_display: assert property (p_gate_closed_in_display) else $error("gate open in display");

   property p_timer_reset_width;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && timer_fire && rst_cnt_reg == 3'h0) ##1 clk_en [*5] |-> reset_pulse ##1 !reset_pulse;
   endproperty
   a_timer_reset_width: assert property (p_timer_reset_width) else $error("reset pulse width wrong");

   property p_single_shot;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && single_shot_switch_reg && !manual_rise && !hold_fall && rst_cnt_reg == 3'h0) |=> rst_cnt_reg == 3'h0;
   endproperty
   a_single_shot: assert property (p_single_shot) else $error("timer fired in single shot");

   property p_close_sets_display;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && gen_rst_b && main_gate_flop_reg && trig_close) |=> display_flop_reg;
   endproperty
   a_close_sets_display: assert property (p_close_sets_display) else $error("display flop not set");

   property p_hold_clamps;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && hold_level) |=> disp_cnt_reg == 32'h0;
   endproperty
   a_hold_clamps: assert property (p_hold_clamps) else $error("timer ran under hold");

   property p_hold_fall_reset;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && hold_fall && rst_cnt_reg == 3'h0) ##1 clk_en |=> reset_pulse;
   endproperty
   a_hold_fall_reset: assert property (p_hold_fall_reset) else $error("no reset after hold");

   property p_event_transfer;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && event_mode) |=> transfer;
   endproperty
   a_event_transfer: assert property (p_event_transfer) else $error("transfer not held");

   property p_reset_clears;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && !gen_rst_b) |=> !display_flop_reg && !main_gate_flop_reg;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("flops not cleared");

   // hold keeps a closed gate closed; only the start button may open it
   property p_hold_blocks_open;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && hold_level && !main_gate_flop_reg && !start_rise) |=> !main_gate_flop_reg;
   endproperty
   a_hold_blocks_open: assert property (p_hold_blocks_open) else $error("gate opened under hold");

   property p_close_transfer;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && gate_close) ##1 clk_en |=> transfer;
   endproperty
   a_close_transfer: assert property (p_close_transfer) else $error("no transfer on close");
endmodule : cmc_control

/* File: dv/cmc_printer_model.sv */
// behavioural printer that answers print commands with a hold level
module cmc_printer_model #(
   parameter int HOLD_CYC = 40
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // bench control
   input  wire logic enable,
   // counter side
   input  wire logic print_cmd,
   output logic      printer_hold
);
   timeunit 1ns;
   timeprecision 1ps;
   logic     cmd_d;
   int       left;

   // hold rises on a new print command and drops when the printout ends
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cmd_d        <= 1'b0;
         left         <= 0;
         printer_hold <= 1'b0;
      end else begin
         cmd_d <= print_cmd;
         if (enable && print_cmd && !cmd_d) begin
            printer_hold <= 1'b1;
            left         <= HOLD_CYC;
         end else if (left != 0) begin
            left <= left - 1;
            if (left == 1) printer_hold <= 1'b0;
         end
      end
   end
endmodule : cmc_printer_model

/* File: dv/cmc_control_bench.sv */
// self-checking bench for the measurement control block
`include "cmc_params.svh"
module cmc_control_bench
   import cmc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        clk_en = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rd_d = 1'b0;
   logic [4:0]  src = 5'h00;
   logic        manual_reset_button = 1'b0;
   logic        start_button = 1'b0;
   logic        stop_button = 1'b0;
   logic        prn_en = 1'b0;
   logic [31:0] reg_rdata;
   logic        printer_hold, count_gate, print_cmd, reset_pulse, transfer;
   logic [31:0] exp_q[$];
   int          seed = 36287;
   int          mismatches = 0;
   int          checks_done = 0;
   int          r, t;

   always #4 clock = ~clock;

   // src bits: channel A, 1 MHz, time base, start event, stop event
   cmc_control uut (
      .clock(clock), .rst_b(rst_b), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .chan_a(src[0]), .ref_1mhz(src[1]), .time_base_out(src[2]),
      .start_event(src[3]), .stop_event(src[4]),
      .manual_reset_button(manual_reset_button), .start_button(start_button),
      .stop_button(stop_button), .printer_hold(printer_hold),
      .count_gate(count_gate), .print_cmd(print_cmd),
      .reset_pulse(reset_pulse), .transfer(transfer)
   );

   cmc_printer_model #(.HOLD_CYC(40)) printer (
      .clock(clock), .rst_b(rst_b), .enable(prn_en),
      .print_cmd(print_cmd), .printer_hold(printer_hold)
   );

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask : wr

   // the expected word waits in the queue until the data cycle
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      reg_rd   <= 1'b0;
   endtask : rd

   task automatic pulse(input int k);
      @(posedge clock);
      src <= src | (5'h01 << k);
      @(posedge clock);
      src <= src & ~(5'h01 << k);
   endtask : pulse

   // counts high cycles of reset and transfer over a fixed window
   task automatic win(input int n, output int rc, output int tc);
      rc = 0;
      tc = 0;
      repeat (n) begin
         @(negedge clock);
         rc += int'(reset_pulse === 1'b1);
         tc += int'(transfer === 1'b1);
      end
   endtask : win

   // one open/close cycle; noise on the unused sources must not leak
   task automatic measure(input logic [2:0] m, input logic ss);
      int          sel, tr0, tr1, rc, tc;
      logic        ev;
      logic [4:0]  nm;
      ev  = (m == CMC_TINT) || (m == CMC_TOTAL);
      sel = ev ? 2 : (m == CMC_PER) ? 1 : 0;
      tr0 = ev ? 3 : 2;
      tr1 = ev ? 4 : 2;
      nm  = (ev ? 5'h03 : 5'h1B) & ~(5'h01 << sel);
      wr(`CMC_ADDR_CTRL, {28'h0, ss, m});
      pulse(tr0);
      rd(`CMC_ADDR_STATUS, 32'h1);
      for (int v = 0; v < 2; v++) begin
         repeat (4) begin
            @(posedge clock);
            src <= (5'($random(seed)) & nm) | (5'(v) << sel);
         end
         @(posedge clock);
         src <= 5'h00;
         @(negedge clock);
         chk("count_gate", 32'(v), {31'h0, count_gate});
      end
      pulse(tr1);
      win(8, rc, tc);
      chk("transfer", ev ? 32'h8 : 32'h2, 32'(tc));
      chk("print_cmd", 32'h1, {31'h0, print_cmd});
      pulse(tr0);
      rd(`CMC_ADDR_STATUS, prn_en ? 32'hA : 32'h2);
   endtask : measure

   // watcher: read data stands only in the cycle after the strobe
   always @(posedge clock) rd_d <= reg_rd;
   always @(negedge clock) begin
      if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
   end

   // guard against a hang anywhere in the sequence
   initial begin
      #800000;
      mismatches++;
      test_done();
   end

   initial begin
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      rd(`CMC_ADDR_CTRL, 32'h0);
      rd(`CMC_ADDR_DISP_TIME, `CMC_DISP_CNT_RESET);
      rd(4'hF, 32'h0);
      wr(`CMC_ADDR_STATUS, 32'hF);
      wr(4'hF, 32'hF);
      rd(`CMC_ADDR_STATUS, 32'h0);
      wr(`CMC_ADDR_DISP_TIME, 32'h14);
      rd(`CMC_ADDR_DISP_TIME, 32'h14);
      // a write while the enable is low must leave the register alone
      clk_en <= 1'b0;
      wr(`CMC_ADDR_DISP_TIME, 32'h99);
      clk_en <= 1'b1;
      rd(`CMC_ADDR_DISP_TIME, 32'h14);
      for (int m = 0; m < 5; m++) begin
         measure(3'(m), 1'b0);
         win(40, r, t);
         chk("reset_pulse", 32'h4, 32'(r));
         chk("print_cmd", 32'h0, {31'h0, print_cmd});
         rd(`CMC_ADDR_STATUS, 32'h0);
      end
      // single shot holds the reading until the button asks for one update
      measure(CMC_FREQ, 1'b1);
      win(100, r, t);
      chk("reset_pulse", 32'h0, 32'(r));
      @(posedge clock);
      manual_reset_button <= 1'b1;
      win(16, r, t);
      chk("reset_pulse", 32'h4, 32'(r));
      chk("transfer", 32'h2, 32'(t));
      chk("print_cmd", 32'h0, {31'h0, print_cmd});
      @(posedge clock);
      manual_reset_button <= 1'b0;
      prn_en              <= 1'b1;
      // printer hold clamps the timer; its end resets at once
      measure(CMC_FREQ, 1'b0);
      win(24, r, t);
      chk("reset_pulse", 32'h0, 32'(r));
      win(20, r, t);
      chk("reset_pulse", 32'h4, 32'(r));
      @(posedge clock);
      prn_en       <= 1'b0;
      start_button <= 1'b1;
      win(8, r, t);
      rd(`CMC_ADDR_STATUS, 32'h1);
      @(posedge clock);
      start_button <= 1'b0;
      stop_button  <= 1'b1;
      win(8, r, t);
      rd(`CMC_ADDR_STATUS, 32'h0);
      chk("print_cmd", 32'h0, {31'h0, print_cmd});
      @(posedge clock);
      stop_button <= 1'b0;
      win(4, r, t);
      test_done();
   end
endmodule : cmc_control_bench
